// File: hdl/tx_level_pkg.sv
/*
 * shared constants and types for the transmit level control block.
 * assumes a single 10 MHz system clock and synchronous active-low reset.
 */
package tx_level_pkg;

    localparam int          ATTEN_W         = 3;
    localparam logic [2:0]  ATTEN_MIN       = 3'h0;   // 0 dB
    localparam logic [2:0]  ATTEN_MAX       = 3'h7;   // -21 dB
    localparam int          ATTEN_STEP_DB   = 3;
    localparam int          FIXED_BIT       = 3;
    localparam int          CTRL_W          = 4;
    localparam logic [3:0]  CTRL_RESET      = 4'h0;
    localparam int          ALC_WINDOW      = 16;
    localparam int          CHIP_PER_BIT    = 8;
    localparam int          CLK_HZ          = 10_000_000;
    localparam int          TX_HOLD_NS      = 10_000;
    localparam int          CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;
    localparam int          TX_HOLD_CYCLES  = (TX_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic        LPF_130K        = 1'b0;
    localparam logic        LPF_195K        = 1'b1;

    typedef struct packed {
        logic       fixed_mode;
        logic [2:0] atten_code;
    } atten_ctrl_t;

    typedef struct packed {
        logic below_low;
        logic above_high;
    } level_cmp_t;

    typedef enum logic [1:0] {
        ALC_IDLE,
        ALC_EVAL,
        ALC_ADJUST,
        ALC_FROZEN
    } alc_state_t;

endpackage

// File: hdl/tx_level_control.sv
/*
 * transmit level control: fixed or automatic attenuation, transmit enable,
 * line driver current limit and thermal shutdown signalling.
 * assumes chip clock strobe, comparator levels and thermal levels arrive
 * asynchronously from the analogue side; register port is on sys_clk_i.
 */
// Behaviour
// - fixed bit set: use register attenuation code
// - eight codes, 3 dB each, 0 to -21
// - fixed bit clear selects automatic level control
// - below low raise, above high lower
// - evaluate one chip clock, adjust next
// - automatic only first 16 chip clocks
// - reset starts at maximum attenuation
// - receive mode keeps reached attenuation
// - transmit enable low while transmitting
// - transmit enable held low briefly after transmit
// - current limit flag follows limit condition
// - thermal shutdown at 160, recover at 135
// - low-pass cutoff selectable 130 or 195 kHz
// - chip clock is eight times bit rate
// - mode flag high transmit, low receive
`timescale 1ns/1ps
`default_nettype none

module tx_level_control
    import tx_level_pkg::*;
#(
    parameter int HOLD_CYCLES = TX_HOLD_CYCLES
) (
    input  wire logic              sys_clk_i,
    input  wire logic              nrst_i,
    input  wire logic              ctrl_wr_i,
    input  wire atten_ctrl_t       ctrl_wdata_i,
    input  wire logic              lpf_sel_i,
    input  wire logic              tx_mode_select_i,
    input  wire logic              chip_clk_i,
    input  wire logic              level_below_low_i,
    input  wire logic              level_above_high_i,
    input  wire logic              drv_at_limit_i,
    input  wire logic              temp_hot_i,
    input  wire logic              temp_cool_i,
    input  wire logic              amp_enable_n_i,
    output atten_ctrl_t            ctrl_rdata_o,
    output logic [ATTEN_W-1:0]     atten_o,
    output logic                   lpf_sel_o,
    output logic                   tx_active_n_o,
    output logic                   tx_active_n_oe_o,
    output logic                   current_limit_flag_o,
    output logic                   driver_enable_o,
    output logic                   thermal_shutdown_o
);

    // two flip-flops on everything from pins or the chip clock domain; each stage
    // resets to the idle level of its pin, so no false edge or false enable follows
    // reset (the amplifier enable pin idles high behind its pull-up)
    localparam int               NSYNC      = 8;
    localparam int               SYNC_TX    = 0;
    localparam int               SYNC_CHIP  = 1;
    localparam int               SYNC_LOW   = 2;
    localparam int               SYNC_HIGH  = 3;
    localparam int               SYNC_LIMIT = 4;
    localparam int               SYNC_HOT   = 5;
    localparam int               SYNC_COOL  = 6;
    localparam int               SYNC_AMP_N = 7;
    localparam logic [NSYNC-1:0] SYNC_IDLE  = 8'h80;
    localparam int               UNUSED_CH  = SYNC_AMP_N;

    wire  [NSYNC-1:0] sync2;
    wire  [NSYNC-1:0] async_in;

    assign async_in[SYNC_TX]    = tx_mode_select_i;
    assign async_in[SYNC_CHIP]  = chip_clk_i;
    assign async_in[SYNC_LOW]   = level_below_low_i;
    assign async_in[SYNC_HIGH]  = level_above_high_i;
    assign async_in[SYNC_LIMIT] = drv_at_limit_i;
    assign async_in[SYNC_HOT]   = temp_hot_i;
    assign async_in[SYNC_COOL]  = temp_cool_i;
    assign async_in[SYNC_AMP_N] = amp_enable_n_i;

    generate
        for (genvar i = 0; i < NSYNC; i++) begin : g_sync
            logic stage1;
            logic stage2;
            always_ff @(posedge sys_clk_i) begin
                if (!nrst_i) begin
                    stage1 <= SYNC_IDLE[i];
                    stage2 <= SYNC_IDLE[i];
                end else begin
                    stage1 <= async_in[i];
                    stage2 <= stage1;
                end
            end
            assign sync2[i] = stage2;   // only the second stage is ever read
        end
    endgenerate

    wire        tx_mode  = sync2[SYNC_TX];
    wire        chip_lvl = sync2[SYNC_CHIP];
    level_cmp_t cmp;
    assign cmp.below_low  = sync2[SYNC_LOW];
    assign cmp.above_high = sync2[SYNC_HIGH];
    wire        at_limit = sync2[SYNC_LIMIT];
    wire        hot      = sync2[SYNC_HOT];
    wire        cool     = sync2[SYNC_COOL];
    wire        amp_en_n = sync2[SYNC_AMP_N];

    // edge detect on the synchronised copies only, for the chip clock and the mode flag
    function automatic logic rising(input logic now_lvl, input logic last_lvl);
        return now_lvl & ~last_lvl;
    endfunction

    logic chip_prev;
    wire  chip_tick = rising(chip_lvl, chip_prev);   // chip clock runs at 8x bit rate
    logic tx_prev;
    wire  tx_start  = rising(tx_mode, tx_prev);

    // control register
    atten_ctrl_t ctrl;
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            ctrl <= CTRL_RESET;
        end else if (ctrl_wr_i) begin
            ctrl <= ctrl_wdata_i;
        end
    end

    // automatic loop state
    alc_state_t                       state;
    alc_state_t                       next_state;
    logic [$clog2(ALC_WINDOW+1)-1:0]  chip_cnt;
    level_cmp_t                       cmp_held;
    logic [ATTEN_W-1:0]               alc_atten;
    logic [ATTEN_W-1:0]               next_alc_atten;

    wire window_open = (chip_cnt < ALC_WINDOW[$bits(chip_cnt)-1:0]);
    wire auto_mode   = ~ctrl.fixed_mode;

    function automatic logic [ATTEN_W-1:0] step_atten(input logic [ATTEN_W-1:0] a, input level_cmp_t c);
        logic [ATTEN_W-1:0] r;
        r = a;
        if (c.below_low && a != ATTEN_MIN) begin
            r = a - 3'h1;       // raise level one 3 dB step
        end else if (c.above_high && a != ATTEN_MAX) begin
            r = a + 3'h1;       // lower level one step
        end
        return r;
    endfunction

    always_comb begin
        next_state     = state;
        next_alc_atten = alc_atten;
        case (state)
            ALC_IDLE: begin
                if (tx_start && auto_mode) begin
                    next_state = ALC_EVAL;
                end
            end
            ALC_EVAL: begin
                if (!tx_mode || !auto_mode || !window_open) begin
                    next_state = ALC_FROZEN;
                end else if (chip_tick) begin
                    next_state = ALC_ADJUST;   // evaluate now, apply next chip clock
                end
            end
            ALC_ADJUST: begin
                if (!tx_mode || !auto_mode) begin
                    next_state = ALC_FROZEN;
                end else if (chip_tick) begin
                    next_alc_atten = step_atten(alc_atten, cmp_held);
                    next_state     = window_open ? ALC_EVAL : ALC_FROZEN;
                end
            end
            ALC_FROZEN: begin
                if (!tx_mode) begin
                    next_state = ALC_IDLE;   // attenuation retained for next frame
                end
            end
            default: begin
                next_state = ALC_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            state     <= ALC_IDLE;
            alc_atten <= ATTEN_MAX;   // minimum level after reset
        end else begin
            state     <= next_state;
            alc_atten <= next_alc_atten;
        end
    end

    // edge history resets to the idle level of both pins
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            chip_prev <= 1'b0;
            tx_prev   <= 1'b0;
        end else begin
            chip_prev <= chip_lvl;
            tx_prev   <= tx_mode;
        end
    end

    // comparators latched at the evaluate tick, so a late change cannot leak into the step
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            cmp_held <= '0;
        end else if (state == ALC_EVAL && chip_tick) begin
            cmp_held <= cmp;
        end
    end

    // chip clocks since transmit began; saturates so the window stays closed until the next transmit start
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i || tx_start) begin
            chip_cnt <= '0;
        end else if (tx_mode && chip_tick && window_open) begin
            chip_cnt <= chip_cnt + 1'b1;
        end
    end

    // selected attenuation: register code in fixed mode, loop value otherwise
    wire [ATTEN_W-1:0] next_atten = ctrl.fixed_mode ? ctrl.atten_code : alc_atten;

    // transmit enable with trailing hold; the pin is open drain, so it is only ever pulled low
    localparam int HW = (HOLD_CYCLES < 2) ? 1 : $clog2(HOLD_CYCLES + 1);
    logic [HW-1:0] hold_cnt;
    wire           hold_busy  = (hold_cnt != '0);
    wire           next_tx_oe = tx_mode | hold_busy;

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            hold_cnt <= '0;
        end else if (tx_mode) begin
            hold_cnt <= HW'(HOLD_CYCLES);
        end else if (hold_busy) begin
            hold_cnt <= hold_cnt - 1'b1;
        end
    end

    // thermal shutdown with hysteresis: trip on hot, release only when cool;
    // hot wins if both comparators read high, so a hot part never re-enables
    logic therm_off;
    wire  next_therm_off = hot ? 1'b1 : (cool ? 1'b0 : therm_off);
    wire  next_drv_en    = ~amp_en_n & ~next_therm_off;              // high-active enable, built from the low-active amplifier enable pin

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            therm_off <= 1'b0;
        end else begin
            therm_off <= next_therm_off;
        end
    end

    // every output below leaves straight from a flip-flop
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            atten_o      <= ATTEN_MAX;
            ctrl_rdata_o <= CTRL_RESET;
        end else begin
            atten_o      <= next_atten;
            ctrl_rdata_o <= ctrl;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            lpf_sel_o <= LPF_130K;
        end else begin
            lpf_sel_o <= lpf_sel_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            tx_active_n_o    <= 1'b0;
            tx_active_n_oe_o <= 1'b0;
        end else begin
            tx_active_n_o    <= 1'b0;
            tx_active_n_oe_o <= next_tx_oe;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            current_limit_flag_o <= 1'b0;
        end else begin
            current_limit_flag_o <= at_limit;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            driver_enable_o    <= 1'b0;
            thermal_shutdown_o <= 1'b0;
        end else begin
            driver_enable_o    <= next_drv_en;
            thermal_shutdown_o <= next_therm_off;
        end
    end

endmodule

`default_nettype wire

// File: dv/tx_level_control_asserts.sv
/* port checker for tx_level_control.
   assumes it is bound into the block and that inputs move away from clock edges. */
`timescale 1ns/1ps
`default_nettype none
module tx_level_control_asserts
    import tx_level_pkg::*;
(
    input wire logic               sys_clk_i,
    input wire logic               nrst_i,
    input wire logic               ctrl_wr_i,
    input wire atten_ctrl_t        ctrl_wdata_i,
    input wire logic               tx_mode_select_i,
    input wire logic               chip_clk_i,
    input wire logic               drv_at_limit_i,
    input wire logic               temp_hot_i,
    input wire logic               temp_cool_i,
    input wire logic               amp_enable_n_i,
    input wire logic [ATTEN_W-1:0] atten_o,
    input wire logic               tx_active_n_oe_o,
    input wire logic               current_limit_flag_o,
    input wire logic               driver_enable_o,
    input wire logic               thermal_shutdown_o
);
    logic       chip_d;
    logic [4:0] ticks;
    // chip ticks since tx start; saturates so the frozen check stays armed
    always_ff @(posedge sys_clk_i) begin
        chip_d <= chip_clk_i;
        ticks  <= (!nrst_i || !tx_mode_select_i) ? 5'h0 : ticks + 5'(chip_clk_i && !chip_d && ticks != 5'h1f);
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    a_reset_max: assert property ($rose(nrst_i) |-> atten_o == ATTEN_MAX) else $error("no max atten");
    a_fixed_apply: assert property (ctrl_wr_i && ctrl_wdata_i.fixed_mode |-> ##2
        atten_o == $past(ctrl_wdata_i.atten_code, 2)) else $error("fixed code not applied");
    a_step_single: assert property (!$past(ctrl_wr_i) && !$past(ctrl_wr_i, 2) && !$stable(atten_o) |->
        {1'b0, atten_o} + 4'h1 == {1'b0, $past(atten_o)} || {1'b0, atten_o} == {1'b0, $past(atten_o)} + 4'h1)
        else $error("atten jumped");
    a_frozen_after: assert property (ticks > 5'h11 && !$past(ctrl_wr_i) && !$past(ctrl_wr_i, 2) |->
        $stable(atten_o)) else $error("atten moved after window");
    a_oe_on: assert property ($rose(tx_mode_select_i) |-> ##[1:4] tx_active_n_oe_o) else $error("no tx enable");
    a_oe_hold: assert property ($fell(tx_mode_select_i) && tx_active_n_oe_o |=> tx_active_n_oe_o [*3])
        else $error("tx enable released early");
    a_current_limit_flag_set: assert property (drv_at_limit_i [*4] |-> current_limit_flag_o) else $error("no limit flag");
    a_current_limit_flag_clear: assert property (!drv_at_limit_i [*4] |-> !current_limit_flag_o) else $error("limit stuck");
    a_thermal_trip: assert property (temp_hot_i [*5] |-> thermal_shutdown_o && !driver_enable_o)
        else $error("no shutdown");
    a_drive_resume: assert property ((temp_cool_i && !temp_hot_i && !amp_enable_n_i) [*6] |->
        driver_enable_o) else $error("driver not resumed");
endmodule
`default_nettype wire

// File: dv/line_driver_model.sv
/* external line driver enable loop.
   assumes the open-drain transmit enable has a pull-up and feeds the amplifier enable. */
`timescale 1ns/1ps
`default_nettype none
module line_driver_model (
    input  wire logic pin_low_i,
    input  wire logic pin_data_i,
    output logic      amp_enable_n_o
);
    // pull-up wins whenever nobody drives the wire
    assign amp_enable_n_o = pin_low_i ? pin_data_i : 1'b1;
endmodule
`default_nettype wire

// File: dv/tb_tx_level_control.sv
/* bench for tx_level_control: fixed codes, automatic stepping, tx enable timing, protection flags.
   assumes the line driver model closes the enable loop and HOLD_CYCLES of 3. */
`timescale 1ns/1ps
`default_nettype none
module tb_tx_level_control
    import tx_level_pkg::*;
;
    logic        sys_clk_i = 1'b0, nrst_i = 1'b0, ctrl_wr_i = 1'b0, lpf_sel_i = 1'b0, tx_mode_select_i = 1'b0;
    logic        chip_clk_i = 1'b0, level_below_low_i = 1'b0, level_above_high_i = 1'b0, drv_at_limit_i = 1'b0;
    logic        temp_hot_i = 1'b0, temp_cool_i = 1'b0, amp_enable_n_i, lpf_sel_o, tx_active_n_o, tx_active_n_oe_o;
    logic        current_limit_flag_o, driver_enable_o, thermal_shutdown_o;
    logic [2:0]  atten_o;
    atten_ctrl_t ctrl_wdata_i = 4'h0, ctrl_rdata_o;
    int          bad_count = 0, comparisons = 0;
    always #50 sys_clk_i = ~sys_clk_i;
    tx_level_control #(
        .HOLD_CYCLES(3)
    ) DUT (
        .sys_clk_i            (sys_clk_i),
        .nrst_i               (nrst_i),
        .ctrl_wr_i            (ctrl_wr_i),
        .ctrl_wdata_i         (ctrl_wdata_i),
        .lpf_sel_i            (lpf_sel_i),
        .tx_mode_select_i     (tx_mode_select_i),
        .chip_clk_i           (chip_clk_i),
        .level_below_low_i    (level_below_low_i),
        .level_above_high_i   (level_above_high_i),
        .drv_at_limit_i       (drv_at_limit_i),
        .temp_hot_i           (temp_hot_i),
        .temp_cool_i          (temp_cool_i),
        .amp_enable_n_i       (amp_enable_n_i),
        .ctrl_rdata_o         (ctrl_rdata_o),
        .atten_o              (atten_o),
        .lpf_sel_o            (lpf_sel_o),
        .tx_active_n_o        (tx_active_n_o),
        .tx_active_n_oe_o     (tx_active_n_oe_o),
        .current_limit_flag_o (current_limit_flag_o),
        .driver_enable_o      (driver_enable_o),
        .thermal_shutdown_o   (thermal_shutdown_o)
    );
    line_driver_model u_drv (.pin_low_i(tx_active_n_oe_o), .pin_data_i(tx_active_n_o), .amp_enable_n_o(amp_enable_n_i));
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        if (bad_count == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input atten_ctrl_t d);
        ctrl_wdata_i = d;
        ctrl_wr_i = 1'b1;
        tick(1);
        ctrl_wr_i = 1'b0;
        tick(2);
    endtask
    // four sys clocks per chip phase, above the three-clock minimum
    task automatic burst(input int n);
        tx_mode_select_i = 1'b1;
        tick(4);
        repeat (n) begin
            chip_clk_i = 1'b1;
            tick(4);
            chip_clk_i = 1'b0;
            tick(4);
        end
    endtask
    task automatic tx_stop();
        int i;
        tx_mode_select_i = 1'b0;
        tick(3);
        chk(4'(tx_active_n_oe_o), 4'h1);
        for (i = 0; i < 12 && tx_active_n_oe_o; i++) tick(1);
        chk(4'(i < 12), 4'h1);
        if (i == 12) finish_test();
    endtask
    task automatic t_fixed();
        for (int c = 0; c < 8; c++) begin
            wr({1'b1, 3'(c)});
            chk(4'(atten_o), 4'(c));
            chk(ctrl_rdata_o, {1'b1, 3'(c)});
        end
        wr(4'hd);
        level_below_low_i = 1'b1;
        burst(6);
        chk({tx_active_n_oe_o, atten_o}, 4'hd);
        tx_stop();
    endtask
    task automatic t_auto();
        wr(4'ha);
        wr(4'h0);
        burst(16);
        chk(4'(atten_o), 4'h0);
        level_below_low_i = 1'b0;
        level_above_high_i = 1'b1;
        burst(6);
        chk(4'(atten_o), 4'h0);
        tx_stop();
        chk(4'(atten_o), 4'h0);
        burst(2);
        chk(4'(atten_o), 4'h1);
        burst(14);
        chk(4'(atten_o), 4'h7);
        level_above_high_i = 1'b0;
        tx_stop();
    endtask
    task automatic t_prot();
        lpf_sel_i = 1'b1;
        drv_at_limit_i = 1'b1;
        tx_mode_select_i = 1'b1;
        tick(6);
        chk({lpf_sel_o, current_limit_flag_o, driver_enable_o, thermal_shutdown_o}, 4'he);
        temp_hot_i = 1'b1;
        drv_at_limit_i = 1'b0;
        tick(6);
        chk({lpf_sel_o, current_limit_flag_o, driver_enable_o, thermal_shutdown_o}, 4'h9);
        temp_hot_i = 1'b0;
        tick(6);
        chk({lpf_sel_o, current_limit_flag_o, driver_enable_o, thermal_shutdown_o}, 4'h9);
        temp_cool_i = 1'b1;
        lpf_sel_i = 1'b0;
        tick(6);
        chk({lpf_sel_o, current_limit_flag_o, driver_enable_o, thermal_shutdown_o}, 4'h2);
        tx_stop();
    endtask
    initial begin
        tick(16);
        nrst_i = 1'b1;
        tick(1);
        chk({tx_active_n_oe_o, atten_o}, 4'h7);
        chk(ctrl_rdata_o, CTRL_RESET);
        chk({lpf_sel_o, current_limit_flag_o, driver_enable_o, thermal_shutdown_o}, 4'h0);
        t_fixed();
        t_auto();
        t_prot();
        finish_test();
    end
endmodule
bind tx_level_control tx_level_control_asserts u_chk (
    .sys_clk_i            (sys_clk_i),
    .nrst_i               (nrst_i),
    .ctrl_wr_i            (ctrl_wr_i),
    .ctrl_wdata_i         (ctrl_wdata_i),
    .tx_mode_select_i     (tx_mode_select_i),
    .chip_clk_i           (chip_clk_i),
    .drv_at_limit_i       (drv_at_limit_i),
    .temp_hot_i           (temp_hot_i),
    .temp_cool_i          (temp_cool_i),
    .amp_enable_n_i       (amp_enable_n_i),
    .atten_o              (atten_o),
    .tx_active_n_oe_o     (tx_active_n_oe_o),
    .current_limit_flag_o (current_limit_flag_o),
    .driver_enable_o      (driver_enable_o),
    .thermal_shutdown_o   (thermal_shutdown_o)
);
`default_nettype wire
